//--- dv/csk_stor_model.sv
// csk_stor_model: storage key array beside main storage, one key per block
// assumes byte addresses of 16 bits; keys are fixed at time zero
`timescale 1ns/1ps
module csk_stor_model import csk_pkg::*; (
  input wire logic [15:0] addr_i, // byte address of the access
  output logic [SKEY_W-1:0] skey_o // key of the addressed block
);
  logic [SKEY_W-1:0] keys [32];
  initial begin
    for (int i = 0; i < 32; i++) begin
      keys[i] = SKEY_W'(i * 7); // mixes zero, matching and fetch-protected keys
    end
  end
  assign skey_o = keys[addr_i[15:BLK_SHIFT]];
endmodule // csk_stor_model

//--- dv/tb_csk_cpu_status.sv
// tb_csk_cpu_status: random and directed checks of run control and key protection
// assumes the storage model supplies the key of each addressed block
`timescale 1ns/1ps
module tb_csk_cpu_status import csk_pkg::*; ;
  logic clk_i = 0, arst_n_i = 0, instr_end = 0, stw_load = 0, mc_err = 0, irq_taken = 0, io_req = 0, e;
  csk_ctl_s ctl = '0;
  logic [63:0] stw_new = '0, stw;
  logic [11:0] irq = '0;
  logic [8:0] acc_hi = '0;
  logic [15:0] addr = '0;
  logic [4:0] skey_m;
  logic [3:0] pk = '0, csw_key;
  logic [31:0] seed = 32'h0000_38a5, r;
  logic running, exec_en, irq_take, timer_en, io_ok, element_check_out, mc_irq, prot_prog, prot_io, acc_ok, elem_rst;
  csk_acc_s acc_w;
  int bad_count = 0, num_checks = 0, cyc = 0;
  logic [8:0] starts [4] = '{9'h080, 9'h020, 9'h008, 9'h080};
  logic [8:0] stops [4] = '{9'h100, 9'h040, 9'h006, 9'h001};
  assign acc_w = {acc_hi, skey_m};
  always #50 clk_i = ~clk_i;
  csk_stor_model stor (.addr_i(addr), .skey_o(skey_m));
  csk_cpu_status DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .ctl_i(ctl), .instr_end_i(instr_end),
    .stw_load_i(stw_load), .stw_new_i(stw_new), .sys_irq_i(irq), .mc_err_i(mc_err), .irq_taken_i(irq_taken),
    .io_start_req_i(io_req), .acc_i(acc_w), .running_o(running), .exec_en_o(exec_en), .irq_take_o(irq_take),
    .timer_en_o(timer_en), .elem_reset_o(elem_rst), .io_start_ok_o(io_ok), .element_check_out_o(element_check_out),
    .mc_irq_o(mc_irq), .prot_prog_o(prot_prog), .prot_io_o(prot_io), .access_ok_o(acc_ok),
    .csw_key_o(csw_key), .program_status_word_o(stw));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [63:0] bt(int b);
    return 64'h1 << (63 - b);
  endfunction
  // h: req, store, chan, internal, display_gen, chan_key
  function automatic logic mism(logic [8:0] h, logic [4:0] k, logic [3:0] p);
    logic [3:0] c;
    c = h[6] ? h[3:0] : p;
    if (h[5] || h[4] || !(h[7] || k[0])) return 1'b0;
    return !(k[4:1] == c || k[4:1] == 4'h0 || c == 4'h0);
  endfunction
  task automatic chk(string n, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    #10;
  endtask
  task automatic pulse(logic [8:0] v);
    ctl = csk_ctl_s'(v);
    tick(1);
    ctl = '0;
  endtask
  task automatic ld(logic [63:0] w);
    stw_new = w;
    stw_load = 1;
    tick(1);
    stw_load = 0;
    chk("stw", stw, w);
  endtask
  // the sync path costs a few edges, so state changes get a bounded wait
  task automatic wait_run(logic v);
    for (int n = 0; n < 10 && running !== v; n++) tick(1);
    chk("running", running, v);
  endtask
  task automatic stint(logic [8:0] h, int n);
    irq = 12'h800;
    tick(1);
    irq = 0;
    pulse(h);
    if (n > 0) tick(n);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    tick(16);
    arst_n_i = 1;
    chk("timer_off", timer_en, 1'b0);
    chk("run_off", running, 1'b0);
    chk("no_reset", elem_rst, 1'b0);
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      if (i % 30 == 0) pk = r[23:20];
      if (i % 30 == 0) ld(64'(pk) << 52);
      acc_hi = {1'b1, r[4], r[5], r[9:6] == 4'h0, r[13:10] == 4'h0, r[17:14]};
      addr = r[31:16];
      #1;
      e = mism(acc_hi, skey_m, pk);
      chk("access_ok", acc_ok, !e);
      tick(1);
      chk("prot_prog", prot_prog, e & !acc_hi[6]);
      chk("prot_io", prot_io, e & acc_hi[6]);
      if (acc_hi[6]) chk("csw_key", csw_key, acc_hi[3:0]);
    end
    acc_hi = '0;
    for (int i = 0; i < 4; i++) begin
      pulse(starts[i]);
      wait_run(1);
      chk("timer_on", timer_en, 1'b1);
      chk("exec_run", exec_en, 1'b1);
      pulse(stops[i]);
      tick(6);
      chk("stop_held", running, 1'b1);
      instr_end = 1;
      tick(1);
      instr_end = 0;
      wait_run(0);
      chk("exec_stop", exec_en, 1'b0);
    end
    ld(bt(14));
    pulse(9'h080);
    wait_run(1);
    io_req = 1;
    chk("exec_wait", exec_en, 1'b0);
    chk("io_wait", io_ok, 1'b0);
    stint(9'h100, 0);
    wait_run(0);
    ld(64'hff00_f000_0000_0000);
    chk("irq_stopped", irq_take, 1'b0);
    pulse(9'h080);
    wait_run(1);
    chk("irq_kept", irq_take, 1'b1);
    chk("io_run", io_ok, 1'b1);
    stint(9'h100, 4);
    instr_end = 1;
    tick(1);
    instr_end = 0;
    tick(3);
    chk("drain_run", running, 1'b1);
    irq_taken = 1;
    tick(1);
    irq_taken = 0;
    wait_run(0);
    ld(bt(15));
    pulse(9'h080);
    wait_run(1);
    chk("io_prob", io_ok, 1'b0);
    mc_err = 1;
    tick(2);
    chk("elc", element_check_out, 1'b1);
    chk("mc_masked", mc_irq, 1'b0);
    ld(bt(13) | bt(15));
    chk("mc_irq", mc_irq, 1'b1);
    mc_err = 0;
    stint(9'h010, 1);
    chk("elem_reset", elem_rst, 1'b1);
    wait_run(0);
    chk("stw_clr", stw, 64'h0);
    ld(64'hff00_f000_0000_0000);
    pulse(9'h080);
    wait_run(1);
    chk("irq_gone", irq_take, 1'b0);
    end_of_test();
  end
endmodule // tb_csk_cpu_status

//--- verilog/csk_cpu_status.sv
// csk_cpu_status: status word, stop/operate control and storage key checking
// assumes the pipeline reports instruction boundaries and interrupt service; storage holds keys
//
// Behaviour
// R1: stopped: no instructions, interrupts stay pending
// R2: stop from switch, external, compare, step, power-on
// R3: start from switch, external start or load
// R4: stop at instruction boundary, immediately when waiting
// R5: service unmasked pending interrupts before stopping
// R6: write-direct stop resets and clears pending
// R7: interval timer frozen while stopped
// R8: no new I/O when stopped, waiting, problem
// R9: 2048-byte blocks carry five-bit keys
// R10: store always checks, fetch when bit set
// R11: comparand is status key or channel key
// R12: keys match if equal or either zero
// R13: key in bits 8-11; channel key reported
// R14: instruction mismatch suppresses access, program interrupt
// R15: I/O mismatch ends transfer, flags channel status
// R16: only real accesses checked; internal addresses bypass
// R17: display generator transfers never checked
// R18: system mask bits 0-7, 16-19 gate sources
// R19: bit 13 masks machine check, check out stays
// R20: bit 14 wait, bit 15 problem
// R21: bits 20-31 cause, 32-33 length code
// R22: 34-35 condition, 36-39 mask, 40-63 address
// R23: sync controls, latch stop until boundary
`timescale 1ns/1ps
module csk_cpu_status import csk_pkg::*; #(
  parameter int IRQ_N = IRQ_W
) (
  input wire logic clk_i, // processor clock
  input wire logic arst_n_i, // async reset, active low
  input wire csk_ctl_s ctl_i, // console and external controls
  input wire logic instr_end_i, // current instruction finished
  input wire logic stw_load_i, // load a whole new status word
  input wire logic [STW_W-1:0] stw_new_i, // new status word
  input wire logic [IRQ_N-1:0] sys_irq_i, // channel and external requests
  input wire logic mc_err_i, // malfunction detected
  input wire logic irq_taken_i, // pipeline serviced the granted interrupt
  input wire logic io_start_req_i, // program asks to start an I/O operation
  input wire csk_acc_s acc_i, // storage access to check
  output logic running_o, // element in operating state
  output logic exec_en_o, // instructions may execute
  output logic irq_take_o, // unmasked interrupt may be taken now
  output logic timer_en_o, // interval timer may update
  output logic elem_reset_o, // element reset pulse
  output logic io_start_ok_o, // new I/O operation may start
  output logic element_check_out_o, // malfunction signal
  output logic mc_irq_o, // machine check interrupt request
  output logic prot_prog_o, // program protection interruption
  output logic prot_io_o, // channel transfer terminate
  output logic access_ok_o, // access may proceed
  output logic [KEY_W-1:0] csw_key_o, // key for channel status word
  output logic [STW_W-1:0] program_status_word_o // current status word
);
  csk_ctl_s sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  csk_run_e run_ff, nxt_run;
  logic stop_pend_ff, nxt_stop_pend;
  logic [STW_W-1:0] stw_ff, nxt_stw;
  logic [IRQ_N-1:0] pend_ff, nxt_pend;
  logic mc_pend_ff, nxt_mc_pend;
  logic prot_prog_ff, prot_io_ff, nxt_prot_prog, nxt_prot_io;
  logic [KEY_W-1:0] csw_key_ff, nxt_csw_key;
  logic [IRQ_N-1:0] smask;
  logic stop_cmd, start_cmd, waiting, problem, unmasked, check, mismatch;
  logic [KEY_W-1:0] comparand;

  // two flops per control line: console switches and remote stop lines are not timed to this clock
  always_comb begin
    nxt_sync1 = ctl_i; // [R23]
    nxt_sync2 = sync1_ff;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // status word fields
  always_comb begin
    smask = {stw_ff[STW_W-1-SMASK_A_LO -: 8], stw_ff[STW_W-1-SMASK_B_LO -: 4]}; // [R18]
    waiting = stw_ff[STW_W-1-WAIT_BIT]; // [R20]
    problem = stw_ff[STW_W-1-PROB_BIT]; // [R20]
    unmasked = |(pend_ff & smask) || (mc_pend_ff && stw_ff[STW_W-1-MCMASK_BIT]); // [R19]
    stop_cmd = sync2_ff.stop_sw || sync2_ff.ext_stop || (sync2_ff.cmp_eq && sync2_ff.cmp_stop)
               || sync2_ff.step; // [R2]
    start_cmd = sync2_ff.start_sw || sync2_ff.ext_start || sync2_ff.ipl; // [R3]
  end

  // run control; power-on reset lands in the stopped state
  always_comb begin
    nxt_run = run_ff;
    nxt_stop_pend = stop_pend_ff || stop_cmd; // [R23]
    unique case (run_ff)
      CSK_STOPPED: begin
        nxt_stop_pend = 1'b0;
        if (start_cmd) nxt_run = CSK_OPERATE; // [R3]
      end
      CSK_OPERATE: begin
        if (nxt_stop_pend && (instr_end_i || waiting)) nxt_run = CSK_DRAIN; // [R4]
      end
      CSK_DRAIN: begin
        // the status swap itself is the pipeline's job; here the stop is only held back
        if (!unmasked) begin
          nxt_run = CSK_STOPPED; // [R5]
          nxt_stop_pend = 1'b0;
        end
      end
      default: nxt_run = CSK_STOPPED;
    endcase
    if (sync2_ff.wd_stop) begin
      nxt_run = CSK_STOPPED; // [R6]
      nxt_stop_pend = 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_ff <= CSK_STOPPED; // [R2]
      stop_pend_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      stop_pend_ff <= nxt_stop_pend;
    end
  end

  // pending requests: arrivals win over service clear
  always_comb begin
    nxt_pend = pend_ff;
    nxt_mc_pend = mc_pend_ff;
    nxt_stw = stw_ff;
    if (irq_taken_i && irq_take_o) begin
      nxt_pend = pend_ff & ~smask;
      if (stw_ff[STW_W-1-MCMASK_BIT]) nxt_mc_pend = 1'b0;
    end
    nxt_pend = nxt_pend | sys_irq_i; // [R1]
    nxt_mc_pend = nxt_mc_pend | mc_err_i; // [R19]
    if (stw_load_i) nxt_stw = stw_new_i; // [R21] [R22]
    // a request arriving in the clearing cycle is kept, so set wins over the discard
    if (sync2_ff.wd_stop) begin
      nxt_pend = sys_irq_i; // [R6]
      nxt_mc_pend = mc_err_i;
      nxt_stw = STW_RST;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_ff <= '0;
      mc_pend_ff <= 1'b0;
      stw_ff <= STW_RST;
    end else begin
      pend_ff <= nxt_pend;
      mc_pend_ff <= nxt_mc_pend;
      stw_ff <= nxt_stw;
    end
  end

  // key check; internal and display-generator accesses bypass it
  always_comb begin
    comparand = acc_i.chan ? acc_i.chan_key : stw_ff[STW_W-1-PKEY_LO -: KEY_W]; // [R11] [R13]
    check = acc_i.req && !acc_i.internal && !acc_i.display_gen
            && (acc_i.store || acc_i.skey[0]); // [R10] [R16] [R17]
    mismatch = check && acc_i.skey[SKEY_W-1 -: KEY_W] != comparand
               && acc_i.skey[SKEY_W-1 -: KEY_W] != KEY_ANY && comparand != KEY_ANY; // [R12] [R9]
    nxt_prot_prog = mismatch && !acc_i.chan; // [R14]
    nxt_prot_io = mismatch && acc_i.chan; // [R15]
    nxt_csw_key = (acc_i.req && acc_i.chan) ? acc_i.chan_key : csw_key_ff; // [R13]
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prot_prog_ff <= 1'b0;
      prot_io_ff <= 1'b0;
      csw_key_ff <= '0;
    end else begin
      prot_prog_ff <= nxt_prot_prog;
      prot_io_ff <= nxt_prot_io;
      csw_key_ff <= nxt_csw_key;
    end
  end

  always_comb begin
    running_o = run_ff != CSK_STOPPED;
    exec_en_o = run_ff == CSK_OPERATE && !waiting; // [R1]
    irq_take_o = running_o && unmasked && !sync2_ff.wd_stop; // [R1] [R5]
    timer_en_o = running_o; // [R7]
    elem_reset_o = sync2_ff.wd_stop; // [R6]
    io_start_ok_o = io_start_req_i && run_ff == CSK_OPERATE && !waiting && !problem; // [R8]
    element_check_out_o = mc_err_i; // [R19]
    mc_irq_o = mc_pend_ff && stw_ff[STW_W-1-MCMASK_BIT] && running_o; // [R19]
    access_ok_o = acc_i.req && !mismatch; // [R14] [R15]
    prot_prog_o = prot_prog_ff;
    prot_io_o = prot_io_ff;
    csw_key_o = csw_key_ff;
    program_status_word_o = stw_ff;
  end

  // run control, status word and interrupt mask checks
  a_stop_no_exec: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R1]
    run_ff == CSK_STOPPED |-> !exec_en_o && !irq_take_o)
    else $error("executing while stopped");
  a_pend_kept: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R1]
    run_ff == CSK_STOPPED && !sync2_ff.wd_stop |=> (pend_ff & $past(pend_ff)) == $past(pend_ff))
    else $error("pending request lost while stopped");
  a_stop_boundary: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R4]
    $past(run_ff) == CSK_OPERATE && $past(stop_pend_ff) && !$past(instr_end_i)
    && !$past(waiting) && !$past(sync2_ff.wd_stop) |-> run_ff == CSK_OPERATE)
    else $error("stopped mid instruction");
  a_wait_stop: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R4]
    run_ff == CSK_OPERATE && stop_pend_ff && waiting && !sync2_ff.wd_stop |=> run_ff == CSK_DRAIN)
    else $error("stop while waiting delayed");
  a_stop_latch: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R23]
    run_ff == CSK_OPERATE && stop_cmd |=> stop_pend_ff || run_ff == CSK_STOPPED)
    else $error("stop request not latched");
  a_start_cmd: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R3]
    run_ff == CSK_STOPPED && start_cmd && !sync2_ff.wd_stop |=> run_ff == CSK_OPERATE)
    else $error("start ignored");
  a_no_irq_start: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R3]
    run_ff == CSK_STOPPED && !start_cmd |=> run_ff == CSK_STOPPED)
    else $error("started without a start command");
  a_drain_first: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R5]
    run_ff == CSK_DRAIN && unmasked && !sync2_ff.wd_stop |=> run_ff == CSK_DRAIN)
    else $error("stopped with unmasked pending");
  a_drain_take: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R5]
    run_ff == CSK_DRAIN && unmasked && !sync2_ff.wd_stop |-> irq_take_o)
    else $error("pending request not offered before stop");
  a_drain_exit: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R5]
    run_ff == CSK_DRAIN && !unmasked |=> run_ff == CSK_STOPPED)
    else $error("drain did not end");
  a_wd_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R6]
    sync2_ff.wd_stop |=> run_ff == CSK_STOPPED && mc_pend_ff == $past(mc_err_i) && pend_ff == $past(sys_irq_i))
    else $error("write-direct stop not applied");
  a_wd_no_irq: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R6]
    sync2_ff.wd_stop |-> !irq_take_o && elem_reset_o)
    else $error("interrupt offered during write-direct stop");
  a_timer_frozen: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R7]
    timer_en_o == (run_ff != CSK_STOPPED))
    else $error("timer runs while stopped");
  a_io_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R8]
    io_start_ok_o |-> !problem && !waiting && run_ff == CSK_OPERATE)
    else $error("io start in wrong state");
  a_exec_wait: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R20]
    waiting |-> !exec_en_o)
    else $error("executing while waiting");
  a_stw_load: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R22]
    stw_load_i && !sync2_ff.wd_stop |=> program_status_word_o == $past(stw_new_i))
    else $error("status word load lost");
  a_mask_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R18]
    irq_take_o && !mc_irq_o |-> (pend_ff & smask) != '0)
    else $error("masked source offered");
  a_mc_mask: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R19]
    mc_err_i && !stw_ff[STW_W-1-MCMASK_BIT] && !stw_load_i && !sync2_ff.wd_stop
    |-> element_check_out_o ##1 (mc_pend_ff && !mc_irq_o))
    else $error("machine check mask wrong");
  a_mc_open: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R19]
    mc_err_i && stw_ff[STW_W-1-MCMASK_BIT] && run_ff == CSK_OPERATE && !stw_load_i && !sync2_ff.wd_stop
    |=> mc_irq_o)
    else $error("unmasked machine check not raised");
  // key checking
  a_zero_key: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R12]
    acc_i.req && (comparand == KEY_ANY || acc_i.skey[SKEY_W-1 -: KEY_W] == KEY_ANY) |-> access_ok_o)
    else $error("zero key refused");
  a_key_refuse: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R10] [R12]
    acc_i.req && acc_i.store && !acc_i.internal && !acc_i.display_gen && comparand != KEY_ANY
    && acc_i.skey[SKEY_W-1 -: KEY_W] != KEY_ANY && acc_i.skey[SKEY_W-1 -: KEY_W] != comparand
    |-> !access_ok_o)
    else $error("mismatching store allowed");
  a_fetch_free: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R10]
    acc_i.req && !acc_i.store && !acc_i.skey[0] |-> access_ok_o)
    else $error("unprotected fetch refused");
  a_proc_key: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R11] [R13]
    acc_i.req && !acc_i.chan
    && acc_i.skey[SKEY_W-1 -: KEY_W] == stw_ff[STW_W-1-PKEY_LO -: KEY_W] |-> access_ok_o)
    else $error("status key refused");
  a_chan_key: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R11]
    acc_i.req && acc_i.chan && acc_i.skey[SKEY_W-1 -: KEY_W] == acc_i.chan_key |-> access_ok_o)
    else $error("channel key refused");
  a_csw_key: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R13]
    acc_i.req && acc_i.chan |=> csw_key_o == $past(acc_i.chan_key))
    else $error("channel key not kept");
  a_prog_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R14]
    acc_i.req && !acc_i.chan && !access_ok_o |=> prot_prog_o && !prot_io_o)
    else $error("program protection not flagged");
  a_io_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R15]
    acc_i.req && acc_i.chan && !access_ok_o |=> prot_io_o && !prot_prog_o)
    else $error("channel protection not flagged");
  a_bypass: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R16]
    acc_i.req && (acc_i.internal || acc_i.display_gen) |=> !prot_prog_o && !prot_io_o)
    else $error("bypass access flagged");
  a_bypass_ok: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R16] [R17]
    acc_i.req && (acc_i.internal || acc_i.display_gen) |-> access_ok_o)
    else $error("bypass access refused");
  a_no_req_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R16]
    !acc_i.req |=> !prot_prog_o && !prot_io_o)
    else $error("flag without access");
  c_stop_drain: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    run_ff == CSK_DRAIN ##1 run_ff == CSK_STOPPED);
  c_start: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    run_ff == CSK_STOPPED ##1 run_ff == CSK_OPERATE);
  c_prot_io: cover property (@(posedge clk_i) disable iff (!arst_n_i) prot_io_o);
  c_prot_prog: cover property (@(posedge clk_i) disable iff (!arst_n_i) prot_prog_o);
  c_wd_stop: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    sync2_ff.wd_stop && running_o);
endmodule // csk_cpu_status

//--- verilog/csk_pkg.sv
// csk_pkg: shared constants and carriers for the status and key protection block
// assumes a single processor clock; bit 0 of the status word is its leftmost bit
package csk_pkg;
  localparam int STW_W = 64;
  localparam int BLK_SHIFT = 11;
  localparam int KEY_W = 4;
  localparam int SKEY_W = 5;
  localparam int IRQ_W = 12;
  localparam int PMASK_W = 4;
  localparam int PM_LO = 36;
  localparam int PKEY_LO = 8;
  localparam int SMASK_A_LO = 0;
  localparam int SMASK_B_LO = 16;
  localparam int MCMASK_BIT = 13;
  localparam int WAIT_BIT = 14;
  localparam int PROB_BIT = 15;
  localparam int CAUSE_LO = 20;
  localparam int CAUSE_W = 12;
  localparam int ILC_LO = 32;
  localparam int CC_LO = 34;
  localparam int IA_LO = 40;
  localparam int IA_W = 24;
  localparam logic [KEY_W-1:0] KEY_ANY = 4'h0;
  localparam logic [STW_W-1:0] STW_RST = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {
    CSK_STOPPED = 2'b00,
    CSK_OPERATE = 2'b01,
    CSK_DRAIN = 2'b10
  } csk_run_e;

  typedef struct packed {
    logic req;
    logic store;
    logic chan;
    logic internal;
    logic display_gen;
    logic [KEY_W-1:0] chan_key;
    logic [SKEY_W-1:0] skey;
  } csk_acc_s;

  typedef struct packed {
    logic stop_sw;
    logic start_sw;
    logic ext_stop;
    logic ext_start;
    logic wd_stop;
    logic ipl;
    logic cmp_eq;
    logic cmp_stop;
    logic step;
  } csk_ctl_s;
endpackage
